/* rtl/cdp_port.sv */
// cdp_port: eight-line port with clocked waveform generation and acquisition FIFOs,
// isolated-variant fixed lines, and an Avalon-MM register slave.
// assumes all inputs synchronous to clock_i except sample clock sources, which are resynced.
// Function
// - empty generation FIFO at out edge: underflow
// - out clock from ai, ao, counter zero
// - outputs update on chosen rising/falling edge
// - out clock from seven sync lines, function line
// - acquired samples leave by DMA stream
// - in edge samples all lines into FIFO
// - each line output, static input, acquisition
// - full acquisition FIFO at in edge: overflow
// - in clock internal sources, chosen edge
// - in clock from sync lines, function line
// - one source may drive every sample clock
// - reset leaves all lines high impedance
// - isolated: six inputs, four outputs fixed
// - static lines follow software access only
// - isolated: one shared enable, default zero
// - isolated: counter direction from any input
// - isolated: outputs export signals or static
// - out edge moves next sample to pins
// - generation samples arrive by DMA stream
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module cdp_port #(
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                             clock_i,
  input  wire logic                             resetn_i,
  input  wire logic [cdp_pkg::ADDR_W-1:0]       avs_address_i,
  input  wire logic                             avs_read_i,
  input  wire logic                             avs_write_i,
  input  wire logic [cdp_pkg::DATA_W-1:0]       avs_writedata_i,
  output logic      [cdp_pkg::DATA_W-1:0]       avs_readdata_o,
  output logic                                  avs_waitrequest_o,
  input  wire logic                             analog_input_sample_clock_i,
  input  wire logic                             analog_output_sample_clock_i,
  input  wire logic                             ctr0_out_i,
  input  wire logic                             prog_func_line_i,
  output logic                                  prog_func_line_oe_n_o,
  input  wire logic [cdp_pkg::SYNC_N-1:0]       sync_bus_lines_i,
  input  wire logic [cdp_pkg::LINES-1:0]        port_lines_i,
  output logic      [cdp_pkg::LINES-1:0]        port_lines_o,
  output logic      [cdp_pkg::LINES-1:0]        port_lines_oe_n_o,
  input  wire logic                             gen_valid_i,
  input  wire logic [cdp_pkg::LINES-1:0]        gen_data_i,
  output logic                                  gen_ready_o,
  output logic                                  acq_valid_o,
  output logic      [cdp_pkg::LINES-1:0]        acq_data_o,
  input  wire logic                             acq_ready_i,
  input  wire logic [cdp_pkg::ISO_IN_N-1:0]     iso_in_i,
  output logic      [cdp_pkg::ISO_OUT_N-1:0]    iso_out_o,
  output logic                                  iso_oe_n_o,
  output logic      [cdp_pkg::CTR_N-1:0]        ctr_updown_o
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam int unsigned MODES_W = cdp_pkg::LINES * cdp_pkg::MODE_W;

  logic [cdp_pkg::CTRL_W-1:0]      ctrl_q;
  logic [MODES_W-1:0]              line_mode_q;
  logic [cdp_pkg::LINES-1:0]       static_out_q;
  cdp_pkg::cdp_clk_sel_t           out_sel_q;
  cdp_pkg::cdp_clk_sel_t           in_sel_q;
  logic [cdp_pkg::ST_STICKY_W-1:0] sticky_q;
  logic [cdp_pkg::ISO_CFG_W-1:0]   iso_cfg_q;
  logic                            wait_q;
  logic [cdp_pkg::DATA_W-1:0]      rdata_q;
  logic                            req;
  logic                            wr_acc;
  logic [cdp_pkg::DATA_W-1:0]      rdata_d;

  // bus slave: one wait cycle, then a single low-waitrequest cycle per access
  assign req    = avs_read_i | avs_write_i;
  assign wr_acc = avs_write_i & ~wait_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= ~(req & wait_q);
      if (avs_read_i && wait_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q       <= '0;
      line_mode_q  <= '0;
      static_out_q <= '0;
      out_sel_q    <= '0;
      in_sel_q     <= '0;
      iso_cfg_q    <= '0;
    end else if (wr_acc) begin
      unique case (avs_address_i)
        cdp_pkg::OFS_CTRL:      ctrl_q <= avs_writedata_i[cdp_pkg::CTRL_W-1:0];
        cdp_pkg::OFS_LINE_MODE: line_mode_q <= avs_writedata_i[MODES_W-1:0];
        cdp_pkg::OFS_STAT_OUT:  static_out_q <= avs_writedata_i[cdp_pkg::LINES-1:0];
        cdp_pkg::OFS_CLK_SEL: begin
          out_sel_q <= avs_writedata_i[cdp_pkg::CLK_OUT_LSB +: cdp_pkg::CLK_SEL_W];
          in_sel_q  <= avs_writedata_i[cdp_pkg::CLK_IN_LSB +: cdp_pkg::CLK_SEL_W];
        end
        cdp_pkg::OFS_ISO_CFG:   iso_cfg_q <= avs_writedata_i[cdp_pkg::ISO_CFG_W-1:0];
        default: ;
      endcase
    end
  end

  // sample clock sources: every one resynced, internal ones included, so that
  // both clocks see an identical source with identical latency
  logic [cdp_pkg::SRC_N-1:0] src_raw;
  logic [cdp_pkg::SRC_N-1:0] src_meta_q;
  logic [cdp_pkg::SRC_N-1:0] src_sync_q;

  assign src_raw = {sync_bus_lines_i, prog_func_line_i, ctr0_out_i,
                    analog_output_sample_clock_i, analog_input_sample_clock_i};

  genvar k;
  generate
    for (k = 0; k < cdp_pkg::SRC_N; k++) begin : g_sync
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          src_meta_q[k] <= 1'b0;
          src_sync_q[k] <= 1'b0;
        end else begin
          src_meta_q[k] <= src_raw[k];
          src_sync_q[k] <= src_meta_q[k];
        end
      end
    end
  endgenerate

  function automatic logic pick(input logic [cdp_pkg::SRC_N-1:0] v,
                                input logic [cdp_pkg::SRC_W-1:0] s);
    pick = (s < cdp_pkg::SRC_W'(cdp_pkg::SRC_N)) ? v[s] : 1'b0;
  endfunction

  logic out_lvl, in_lvl, out_prev_q, in_prev_q, out_edge, in_edge;

  // both selects index the same source vector, so one source can clock both
  assign out_lvl = pick(src_sync_q, out_sel_q.src);
  assign in_lvl  = pick(src_sync_q, in_sel_q.src);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_prev_q <= 1'b0;
      in_prev_q  <= 1'b0;
    end else begin
      out_prev_q <= out_lvl;
      in_prev_q  <= in_lvl;
    end
  end

  // a source switch can make one false edge; reselect only while disabled
  assign out_edge = out_sel_q.falling ? (out_prev_q & ~out_lvl)
                                      : (~out_prev_q & out_lvl);
  assign in_edge  = in_sel_q.falling ? (in_prev_q & ~in_lvl)
                                     : (~in_prev_q & in_lvl);

  // generation FIFO
  logic [cdp_pkg::LINES-1:0] gen_mem [DEPTH];
  logic [AW-1:0]             gen_wr_q, gen_rd_q;
  logic [CW-1:0]             gen_cnt_q, gen_cnt_d;
  logic                      gen_ready_q, gen_push, gen_pop, gen_under;
  logic [cdp_pkg::LINES-1:0] gen_word_q;

  assign gen_push  = gen_valid_i & gen_ready_q;
  assign gen_pop   = out_edge & ctrl_q[cdp_pkg::CTRL_GEN_EN] & (gen_cnt_q != '0);
  assign gen_under = out_edge & ctrl_q[cdp_pkg::CTRL_GEN_EN] & (gen_cnt_q == '0);
  assign gen_cnt_d = gen_cnt_q + CW'(gen_push) - CW'(gen_pop);

  always_ff @(posedge clock_i) begin
    if (gen_push) begin
      gen_mem[gen_wr_q] <= gen_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gen_wr_q    <= '0;
      gen_rd_q    <= '0;
      gen_cnt_q   <= '0;
      gen_ready_q <= 1'b0;
      gen_word_q  <= '0;
    end else begin
      gen_cnt_q   <= gen_cnt_d;
      gen_ready_q <= gen_cnt_d != FULL_CNT;
      if (gen_push) begin
        gen_wr_q <= gen_wr_q + AW'(1);
      end
      if (gen_pop) begin
        gen_word_q <= gen_mem[gen_rd_q];
        gen_rd_q   <= gen_rd_q + AW'(1);
      end
    end
  end

  assign gen_ready_o = gen_ready_q;

  // acquisition FIFO with a registered head for the DMA stream
  logic [cdp_pkg::LINES-1:0] acq_mem [DEPTH];
  logic [AW-1:0]             acq_wr_q, acq_rd_q;
  logic [CW-1:0]             acq_cnt_q;
  logic                      acq_push, acq_over, acq_load, acq_valid_q;
  logic [cdp_pkg::LINES-1:0] acq_data_q;

  assign acq_push = in_edge & ctrl_q[cdp_pkg::CTRL_ACQ_EN] & (acq_cnt_q != FULL_CNT);
  assign acq_over = in_edge & ctrl_q[cdp_pkg::CTRL_ACQ_EN] & (acq_cnt_q == FULL_CNT);
  assign acq_load = (acq_cnt_q != '0) & (~acq_valid_q | acq_ready_i);

  always_ff @(posedge clock_i) begin
    if (acq_push) begin
      acq_mem[acq_wr_q] <= port_lines_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acq_wr_q    <= '0;
      acq_rd_q    <= '0;
      acq_cnt_q   <= '0;
      acq_valid_q <= 1'b0;
      acq_data_q  <= '0;
    end else begin
      acq_cnt_q <= acq_cnt_q + CW'(acq_push) - CW'(acq_load);
      if (acq_push) begin
        acq_wr_q <= acq_wr_q + AW'(1);
      end
      if (acq_load) begin
        acq_data_q  <= acq_mem[acq_rd_q];
        acq_rd_q    <= acq_rd_q + AW'(1);
        acq_valid_q <= 1'b1;
      end else if (acq_ready_i) begin
        acq_valid_q <= 1'b0;
      end
    end
  end

  assign acq_valid_o = acq_valid_q;
  assign acq_data_o  = acq_data_q;

  // sticky errors: a new event wins over a clear in the same cycle
  logic [cdp_pkg::ST_STICKY_W-1:0] sticky_set, sticky_clr;
  assign sticky_set = {acq_over, gen_under};
  assign sticky_clr = (wr_acc && avs_address_i == cdp_pkg::OFS_STATUS)
                    ? avs_writedata_i[cdp_pkg::ST_STICKY_W-1:0] : '0;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sticky_q <= '0;
    end else begin
      sticky_q <= (sticky_q & ~sticky_clr) | sticky_set;
    end
  end

  // port line drivers; every line is an input until software says otherwise
  logic [cdp_pkg::LINES-1:0] port_out_q, port_oe_n_q, wave_out_mask;
  logic                      pfl_oe_n_q;

  genvar i;
  generate
    for (i = 0; i < cdp_pkg::LINES; i++) begin : g_line
      logic [cdp_pkg::MODE_W-1:0] mode;
      assign mode = line_mode_q[i*cdp_pkg::MODE_W +: cdp_pkg::MODE_W];
      assign wave_out_mask[i] = mode == cdp_pkg::MODE_WAVE_OUT;
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          port_out_q[i]  <= 1'b0;
          port_oe_n_q[i] <= 1'b1;
        end else begin
          port_oe_n_q[i] <= ~(mode == cdp_pkg::MODE_STATIC_OUT ||
                              mode == cdp_pkg::MODE_WAVE_OUT);
          port_out_q[i]  <= (mode == cdp_pkg::MODE_WAVE_OUT)   ? gen_word_q[i] :
                            (mode == cdp_pkg::MODE_STATIC_OUT) ? static_out_q[i] : 1'b0;
        end
      end
    end
  endgenerate

  // function line is only ever a clock source here, never driven
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pfl_oe_n_q <= 1'b1;
    end else begin
      pfl_oe_n_q <= 1'b1;
    end
  end

  assign port_lines_o          = port_out_q;
  assign port_lines_oe_n_o     = port_oe_n_q;
  assign prog_func_line_oe_n_o = pfl_oe_n_q;

  // isolated variant: fixed inputs and outputs, one shared enable
  logic [cdp_pkg::ISO_OUT_N-1:0] iso_out_q;
  logic                          iso_oe_n_q;
  logic [cdp_pkg::CTR_N-1:0]     updown_q;

  generate
    for (i = 0; i < cdp_pkg::ISO_OUT_N; i++) begin : g_iso_out
      logic [cdp_pkg::ISO_EXP_SRC_W-1:0] esrc;
      logic                              exp_en, val;
      assign esrc   = iso_cfg_q[cdp_pkg::ISO_SRC_LSB + i*cdp_pkg::ISO_EXP_SRC_W +:
                                cdp_pkg::ISO_EXP_SRC_W];
      assign exp_en = iso_cfg_q[cdp_pkg::ISO_EXP_LSB + i];
      // export sources: 0..6 sync bus, 7 counter zero output
      assign val = exp_en ? ((esrc < cdp_pkg::ISO_EXP_SRC_W'(cdp_pkg::SYNC_N))
                             ? src_sync_q[cdp_pkg::SRC_SYNC0 + esrc] : src_sync_q[cdp_pkg::SRC_CTR0])
                          : iso_cfg_q[cdp_pkg::ISO_STAT_LSB + i];
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          iso_out_q[i] <= 1'b0;
        end else begin
          iso_out_q[i] <= ctrl_q[cdp_pkg::CTRL_ISO_OE] & val;
        end
      end
    end
    for (i = 0; i < cdp_pkg::CTR_N; i++) begin : g_updown
      logic [cdp_pkg::ISO_UD_W-1:0] usel;
      assign usel = iso_cfg_q[cdp_pkg::ISO_UD_LSB + i*cdp_pkg::ISO_UD_W +: cdp_pkg::ISO_UD_W];
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          updown_q[i] <= 1'b0;
        end else begin
          updown_q[i] <= (usel < cdp_pkg::ISO_UD_W'(cdp_pkg::ISO_IN_N)) ? iso_in_i[usel] : 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      iso_oe_n_q <= 1'b1;
    end else begin
      iso_oe_n_q <= ~ctrl_q[cdp_pkg::CTRL_ISO_OE];
    end
  end

  assign iso_out_o    = iso_out_q;
  assign iso_oe_n_o   = iso_oe_n_q;
  assign ctr_updown_o = updown_q;

  // register read view; static inputs sampled at the read itself
  always_comb begin
    rdata_d = '0;
    unique case (avs_address_i)
      cdp_pkg::OFS_CTRL:      rdata_d[cdp_pkg::CTRL_W-1:0] = ctrl_q;
      cdp_pkg::OFS_LINE_MODE: rdata_d[MODES_W-1:0] = line_mode_q;
      cdp_pkg::OFS_STAT_OUT:  rdata_d[cdp_pkg::LINES-1:0] = static_out_q;
      cdp_pkg::OFS_STAT_IN:   rdata_d[cdp_pkg::LINES-1:0] = port_lines_i;
      cdp_pkg::OFS_CLK_SEL: begin
        rdata_d[cdp_pkg::CLK_OUT_LSB +: cdp_pkg::CLK_SEL_W] = out_sel_q;
        rdata_d[cdp_pkg::CLK_IN_LSB +: cdp_pkg::CLK_SEL_W]  = in_sel_q;
      end
      cdp_pkg::OFS_STATUS: begin
        rdata_d[cdp_pkg::ST_STICKY_W-1:0]   = sticky_q;
        rdata_d[cdp_pkg::ST_GEN_EMPTY]      = gen_cnt_q == '0;
        rdata_d[cdp_pkg::ST_ACQ_FULL]       = acq_cnt_q == FULL_CNT;
      end
      cdp_pkg::OFS_ISO_CFG:   rdata_d[cdp_pkg::ISO_CFG_W-1:0] = iso_cfg_q;
      cdp_pkg::OFS_ISO_IN:    rdata_d[cdp_pkg::ISO_IN_N-1:0] = iso_in_i;
      default: ;
    endcase
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_bus_req; req && wait_q; endsequence
  sequence s_bus_ack; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence

  a_bus_answer: assert property (s_bus_req |=> s_bus_ack)
    else $error("bus access not answered in one cycle");
  a_underflow_flag: assert property (
    out_edge && ctrl_q[cdp_pkg::CTRL_GEN_EN] && gen_cnt_q == '0
    |=> sticky_q[cdp_pkg::ST_UNDERFLOW]) else $error("underflow not flagged");
  a_overflow_flag: assert property (
    in_edge && ctrl_q[cdp_pkg::CTRL_ACQ_EN] && acq_cnt_q == FULL_CNT
    |=> sticky_q[cdp_pkg::ST_OVERFLOW] && acq_cnt_q <= FULL_CNT)
    else $error("overflow not flagged");
  a_acq_capture: assert property (
    acq_push |=> acq_mem[$past(acq_wr_q)] == $past(port_lines_i))
    else $error("acquired word differs from lines");
  // only lines in waveform output mode one cycle earlier must follow the sample
  sequence s_gen_load; gen_word_q == $past(gen_mem[gen_rd_q]); endsequence
  sequence s_gen_drive;
    ((port_out_q ^ $past(gen_word_q)) & $past(wave_out_mask)) == '0;
  endsequence
  a_gen_update: assert property (
    gen_pop |=> s_gen_load ##1 s_gen_drive)
    else $error("port lines not updated from sample");
  a_reset_hiz: assert property (
    $rose(resetn_i) |-> (&port_lines_oe_n_o) && prog_func_line_oe_n_o)
    else $error("lines driven after reset");
  a_static_read: assert property (
    avs_read_i && wait_q && avs_address_i == cdp_pkg::OFS_STAT_IN
    |=> avs_readdata_o[cdp_pkg::LINES-1:0] == $past(port_lines_i))
    else $error("static read not sampled at access");
  a_iso_oe_shared: assert property (
    iso_oe_n_o |-> iso_out_o == '0) else $error("isolated output set while disabled");
  a_updown_sel: assert property (
    ##1 ctr_updown_o[0] == ($past(iso_cfg_q[cdp_pkg::ISO_UD_LSB +: cdp_pkg::ISO_UD_W]) <
        cdp_pkg::ISO_UD_W'(cdp_pkg::ISO_IN_N) ?
        $past(iso_in_i[iso_cfg_q[cdp_pkg::ISO_UD_LSB +: cdp_pkg::ISO_UD_W]]) : 1'b0))
    else $error("counter direction select wrong");

endmodule // cdp_port

/* common/cdp_pkg.sv */
// cdp_pkg: register map, field positions and types of the correlated digital port.
// assumes a 32-bit Avalon-MM slave with byte addresses; one aligned word per register.
package cdp_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LINES  = 8;
  localparam int unsigned SYNC_N = 7;
  localparam int unsigned ISO_IN_N  = 6;
  localparam int unsigned ISO_OUT_N = 4;
  localparam int unsigned CTR_N     = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_LINE_MODE = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT_OUT  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT_IN   = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_CLK_SEL   = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_ISO_CFG   = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_ISO_IN    = 5'h1C;

  // control bits
  localparam int unsigned CTRL_GEN_EN = 0;
  localparam int unsigned CTRL_ACQ_EN = 1;
  localparam int unsigned CTRL_ISO_OE = 2;
  localparam int unsigned CTRL_W      = 3;

  // status bits: 0/1 sticky, write one to clear; 2/3 live
  localparam int unsigned ST_UNDERFLOW = 0;
  localparam int unsigned ST_OVERFLOW  = 1;
  localparam int unsigned ST_GEN_EMPTY = 2;
  localparam int unsigned ST_ACQ_FULL  = 3;
  localparam int unsigned ST_STICKY_W  = 2;

  // per-line mode, two bits per line
  localparam int unsigned MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_STATIC_IN  = 2'h0;
  localparam logic [MODE_W-1:0] MODE_STATIC_OUT = 2'h1;
  localparam logic [MODE_W-1:0] MODE_WAVE_OUT   = 2'h2;
  localparam logic [MODE_W-1:0] MODE_WAVE_IN    = 2'h3;

  // sample clock sources
  localparam int unsigned SRC_W  = 4;
  localparam int unsigned SRC_N  = 11;
  localparam logic [SRC_W-1:0] SRC_AI    = 4'h0;
  localparam logic [SRC_W-1:0] SRC_AO    = 4'h1;
  localparam logic [SRC_W-1:0] SRC_CTR0  = 4'h2;
  localparam logic [SRC_W-1:0] SRC_PFL   = 4'h3;
  localparam logic [SRC_W-1:0] SRC_SYNC0 = 4'h4;

  typedef struct packed {
    logic             falling;
    logic [SRC_W-1:0] src;
  } cdp_clk_sel_t;

  localparam int unsigned CLK_OUT_LSB = 0;
  localparam int unsigned CLK_IN_LSB  = 8;
  localparam int unsigned CLK_SEL_W   = 5;

  // isolated variant configuration fields
  localparam int unsigned ISO_EXP_SRC_W = 3;
  localparam int unsigned ISO_STAT_LSB  = 0;
  localparam int unsigned ISO_EXP_LSB   = 4;
  localparam int unsigned ISO_SRC_LSB   = 8;
  localparam int unsigned ISO_UD_LSB    = 20;
  localparam int unsigned ISO_UD_W      = 3;
  localparam int unsigned ISO_CFG_W     = 26;

endpackage

/* sim/cdp_far_model.sv */
// cdp_far_model: host memory side of both DMA streams and the signals on the port pins.
// assumes the bench queues generation words with push and reads captured words from got_q.
`timescale 1ns/100ps
module cdp_far_model (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       stall_i,
  input  wire logic       gen_ready_i,
  output logic            gen_valid_o,
  output logic      [7:0] gen_data_o,
  input  wire logic       acq_valid_i,
  input  wire logic [7:0] acq_data_i,
  output logic            acq_ready_o,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] lines_o
);
  logic [7:0] gen_q[$];
  logic [7:0] got_q[$];
  task automatic push(input logic [7:0] w);
    gen_q.push_back(w);
  endtask
  // undriven lines float up on the weak pull-up
  assign lines_o = (~oe_n_i & drv_i) | (oe_n_i & ~ext_en_i) | (oe_n_i & ext_en_i & ext_val_i);
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gen_valid_o <= 1'b0;
      gen_data_o  <= 8'h00;
      acq_ready_o <= 1'b0;
    end else begin
      if (gen_valid_o && gen_ready_i) gen_q.delete(0);
      gen_valid_o <= gen_q.size() != 0;
      // idle data toggles so a stale word is never mistaken for a fresh one
      gen_data_o  <= (gen_q.size() != 0) ? gen_q[0] : ~gen_data_o;
      if (acq_valid_i && acq_ready_o) got_q.push_back(acq_data_i);
      acq_ready_o <= !stall_i;
    end
  end
endmodule // cdp_far_model

/* sim/tb_correlated_digital_io_port.sv */
// tb_correlated_digital_io_port: self-checking bench driving registers, sample clocks and pins.
// assumes cdp_port with a shallow FIFO and the far-side model above.
`timescale 1ns/100ps
module tb_correlated_digital_io_port;
  localparam int D = 4;
  logic clock_i = 1'b0, resetn_i = 1'b0, rd = 1'b0, wr = 1'b0, stall = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wd = 32'h00000000, r;
  logic [10:0] src_lv = 11'h000;
  logic [5:0] iso = 6'h00;
  logic [7:0] ev = 8'h00, een = 8'h00, w, pin, pdrv, poe;
  logic [7:0] exp_q[$];
  logic gv, gr, av, ar, pfl_oe, iso_oe, wrq;
  logic [7:0] gd, ad;
  logic [3:0] iso_o;
  logic [1:0] ud;
  int fail_count = 0, cmp_count = 0, seed = 59332, cyc = 0;
  always #50 clock_i = ~clock_i;
  cdp_port #(.DEPTH(D)) u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(r),
    .avs_waitrequest_o(wrq), .analog_input_sample_clock_i(src_lv[0]),
    .analog_output_sample_clock_i(src_lv[1]), .ctr0_out_i(src_lv[2]),
    .prog_func_line_i(src_lv[3]), .prog_func_line_oe_n_o(pfl_oe),
    .sync_bus_lines_i(src_lv[10:4]), .port_lines_i(pin), .port_lines_o(pdrv),
    .port_lines_oe_n_o(poe), .gen_valid_i(gv), .gen_data_i(gd), .gen_ready_o(gr),
    .acq_valid_o(av), .acq_data_o(ad), .acq_ready_i(ar), .iso_in_i(iso), .iso_out_o(iso_o),
    .iso_oe_n_o(iso_oe), .ctr_updown_o(ud));
  cdp_far_model u_far (.clock_i(clock_i), .resetn_i(resetn_i), .stall_i(stall),
    .gen_ready_i(gr), .gen_valid_o(gv), .gen_data_o(gd), .acq_valid_i(av), .acq_data_i(ad),
    .acq_ready_o(ar), .drv_i(pdrv), .oe_n_i(poe), .ext_en_i(een), .ext_val_i(ev),
    .lines_o(pin));
  function automatic logic exp_ud(input int sel, input logic [5:0] v);
    return (sel < 6) ? v[sel] : 1'b0;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w_en, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock_i);
    addr <= a;
    wd   <= d;
    wr   <= w_en;
    rd   <= !w_en;
    do @(posedge clock_i); while (wrq !== 1'b0);
    q = r;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // active edge then back to idle; six clocks per level keeps edges apart
  task automatic pulse(input int s, input logic f);
    @(posedge clock_i);
    src_lv[s] <= ~f;
    repeat (6) @(posedge clock_i);
    src_lv[s] <= f;
    repeat (6) @(posedge clock_i);
  endtask
  // a write lands at the answer edge; the pins show it one edge later, settle waits two
  task automatic settle;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic summarize;
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    logic [31:0] q;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    chk("oe after reset", {pfl_oe, iso_oe, poe}, 32'h000003FF);
    chk("iso out after reset", iso_o, 32'h00000000);
    bus(1'b1, cdp_pkg::OFS_LINE_MODE, 32'h00005555, q);
    w = $random(seed);
    bus(1'b1, cdp_pkg::OFS_STAT_OUT, {24'h000000, w}, q);
    settle();
    chk("static out pins", {poe, pdrv}, {16'h0000, 8'h00, w});
    bus(1'b1, cdp_pkg::OFS_LINE_MODE, 32'h00000000, q);
    een <= 8'hFF;
    ev  <= $random(seed);
    bus(1'b0, cdp_pkg::OFS_STAT_IN, 32'h00000000, q);
    chk("static in", q, {24'h000000, ev});
    chk("static in oe", poe, 32'h000000FF);
    een <= 8'h00;
    bus(1'b1, cdp_pkg::OFS_LINE_MODE, 32'h0000AAAA, q);
    for (int s = 0; s < 11; s++) begin
      for (int f = 0; f < 2; f++) begin
        bus(1'b1, cdp_pkg::OFS_CTRL, 32'h00000000, q);
        bus(1'b1, cdp_pkg::OFS_CLK_SEL, {27'h0000000, f[0], s[3:0]}, q);
        src_lv[s] <= f[0];
        w = $random(seed);
        u_far.push(w);
        bus(1'b1, cdp_pkg::OFS_CTRL, 32'h00000001, q);
        pulse(s, f[0]);
        chk("wave out word", {poe, pdrv}, {16'h0000, 8'h00, w});
        pulse(s, f[0]);
        chk("held on underflow", pdrv, {24'h000000, w});
        bus(1'b0, cdp_pkg::OFS_STATUS, 32'h00000000, q);
        chk("underflow flag", q[cdp_pkg::ST_UNDERFLOW], 32'h00000001);
        chk("gen empty", q[cdp_pkg::ST_GEN_EMPTY], 32'h00000001);
        bus(1'b1, cdp_pkg::OFS_STATUS, 32'h00000001, q);
        bus(1'b0, cdp_pkg::OFS_STATUS, 32'h00000000, q);
        chk("underflow cleared", q[cdp_pkg::ST_UNDERFLOW], 32'h00000000);
        bus(1'b1, cdp_pkg::OFS_CTRL, 32'h00000000, q);
        src_lv[s] <= 1'b0;
      end
    end
    // same sync line clocks both directions, input on its falling edge
    bus(1'b1, cdp_pkg::OFS_CLK_SEL, 32'h00001606, q);
    bus(1'b1, cdp_pkg::OFS_LINE_MODE, 32'h0000FFFF, q);
    stall  <= 1'b1;
    een    <= 8'hFF;
    src_lv[6] <= 1'b1;
    bus(1'b1, cdp_pkg::OFS_CTRL, 32'h00000002, q);
    chk("wave in oe", poe, 32'h000000FF);
    for (int k = 0; k < D + 2; k++) begin
      w = $random(seed);
      ev <= w;
      exp_q.push_back(w);
      pulse(6, 1'b1);
    end
    bus(1'b0, cdp_pkg::OFS_STATUS, 32'h00000000, q);
    chk("overflow flag", q[cdp_pkg::ST_OVERFLOW], 32'h00000001);
    chk("acq full", q[cdp_pkg::ST_ACQ_FULL], 32'h00000001);
    stall <= 1'b0;
    repeat (20) @(posedge clock_i);
    chk("words kept", 32'(u_far.got_q.size() >= D), 32'h00000001);
    for (int k = 0; k < D && k < u_far.got_q.size(); k++)
      chk("acq word", u_far.got_q[k], exp_q[k]);
    bus(1'b1, cdp_pkg::OFS_CTRL, 32'h00000000, q);
    for (int k = 0; k < 7; k++) begin
      iso <= $random(seed);
      src_lv[4] <= k[0];
      // output 0 exports sync line 0, the other three stay static
      bus(1'b1, cdp_pkg::OFS_ISO_CFG, {6'h00, 3'(6 - k), 3'(k), 12'h000, 4'h1, 4'(k + 9)},
          q);
      settle();
      chk("ctr dir", ud, {30'h00000000, exp_ud(6 - k, iso), exp_ud(k, iso)});
      chk("iso off", {iso_oe, iso_o}, 32'h00000010);
      bus(1'b1, cdp_pkg::OFS_CTRL, 32'h00000004, q);
      settle();
      chk("iso on", {iso_oe, iso_o}, {27'h0000000, 1'b0, 3'((k + 9) >> 1), k[0]});
      bus(1'b0, cdp_pkg::OFS_ISO_IN, 32'h00000000, q);
      chk("iso in", q, {26'h0000000, iso});
      bus(1'b1, cdp_pkg::OFS_CTRL, 32'h00000000, q);
    end
    summarize();
  end
endmodule // tb_correlated_digital_io_port
